// File: rtl/bapr_core.sv
// Purpose: access path from cache bus to external bus, monitor and reset handling
// Assumes: external cycle engine and cache arrays sit outside this block
// Notes: single system clock core_clk, synchronous resets
//
// What this block does
// - sample external bus while released; capture on strobe
// - strobe only in column address cycle
// - power-on reset negates signals, buffers off
// - only power-on reset initialises control settings
// - manual reset lets running cycle finish
// - manual reset cancels fill at longword boundary
// - refresh counter holds during manual reset
// - master accepts arbitration during manual reset
// - master-only reset keeps grant asserted while requested, keeps release
// - cache bus reaches internal bus, never reverse
// - cacheable read: lookup, hit, or four-beat fill
// - fills always use longword accesses
// - through accesses keep size; fetches longword
// - through or peripheral read adds decision cycle
// - cacheable write updates hit line, writes through
// - write completion immediate when bus owned
// - single-entry write buffer frees internal bus
// - reads stall until fully complete
// - external-to-external DMA waits for prior write
`default_nettype none
module bapr_core
	import bapr_pkg::*;
(
	// clock and resets
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic              manual_rst,
	// configuration
	input  wire logic              slave_mode,
	input  wire logic              cache_enable,
	input  wire logic [15:0]       refresh_interval,
	// break comparison settings
	input  wire logic [ADDR_W-1:0] break_addr,
	input  wire logic [ADDR_W-1:0] break_mask,
	input  wire logic              break_write,
	input  wire logic              break_any_dir,
	// external bus pins
	input  wire logic              bus_cycle_strobe_n,
	input  wire logic [ADDR_W-1:0] ext_addr_in,
	input  wire logic              ext_rd_wr_n,
	input  wire logic              bus_release_request_n,
	output logic                   bus_grant_out_n,
	output logic                   out_enable_n,
	output logic                   ctrl_active,
	// cpu / transfer engine request on cache bus
	input  wire bapr_req_s         req,
	input  wire logic              cache_hit,
	input  wire logic              bus_owned,
	input  wire logic              src_ext,
	input  wire logic              dst_ext,
	output logic                   req_ready,
	output logic                   rd_done,
	output logic                   wr_done,
	output logic [DATA_W-1:0]      rd_data,
	output logic                   cache_write,
	output logic                   cache_unsafe,
	// external cycle engine
	output bapr_ext_s              ext_req,
	input  wire logic              ext_ready,
	input  wire logic              ext_done,
	input  wire logic [DATA_W-1:0] ext_rdata,
	// monitor and refresh
	output bapr_mon_s              monitor,
	output logic                   refresh_req
);
	typedef struct packed {
		logic [1:0]        grant_sync;
		logic [1:0]        strobe_sync;
		logic [ADDR_W-1:0] addr_s1;
		logic [ADDR_W-1:0] addr_s2;
		logic [1:0]        rw_sync;
		logic [1:0]        mrst_sync;
		bapr_state_e       state;
		bapr_ext_s         wbuf;
		logic              wbuf_busy;
		bapr_ext_s         cur;
		logic              cur_busy;
		logic [1:0]        beat;
		logic              fill_cancel;
		logic              unsafe;
		logic              grant_n;
		logic [15:0]       rcnt;
		logic              rreq;
		bapr_mon_s         mon;
		logic              rdone;
		logic              wdone;
		logic [DATA_W-1:0] rdat;
		logic              cwr;
	} bapr_st_s;

	bapr_st_s st;
	bapr_st_s next_st;

	function automatic logic [2:0] area_of(input logic [CPU_ADDR_W-1:0] a);
		area_of = a[CPU_ADDR_W-1:CPU_ADDR_W-3];
	endfunction

	function automatic bapr_ext_s mk_ext(input logic w, input logic [1:0] sz,
		input logic [CPU_ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		mk_ext = '{valid: 1'b1, write: w, size: sz, addr: a, wdata: d};
	endfunction

	logic released;
	logic mrst;
	logic ext_busy;
	logic wr_accept;
	logic need_rd;

	always_comb begin
		mrst     = st.mrst_sync[1];
		released = ~st.grant_sync[1] & ~st.grant_n;
		ext_busy = st.cur_busy;
		need_rd  = req.valid & ~req.write;
		// buffer full stalls a second write; external-to-external DMA waits for write
		wr_accept = req.valid & req.write & ~st.wbuf_busy & bus_owned;
		next_st = st;
		next_st.grant_sync  = {st.grant_sync[0], bus_release_request_n};
		next_st.strobe_sync = {st.strobe_sync[0], bus_cycle_strobe_n};
		next_st.addr_s1     = ext_addr_in;
		next_st.addr_s2     = st.addr_s1;
		next_st.rw_sync     = {st.rw_sync[0], ext_rd_wr_n};
		next_st.mrst_sync   = {st.mrst_sync[0], manual_rst};
		next_st.rdone = 1'b0;
		next_st.wdone = 1'b0;
		next_st.cwr   = 1'b0;
		next_st.mon.hit = 1'b0;
		// monitor capture while bus released, strobe marks column cycle
		if (released && !st.strobe_sync[1]) begin
			next_st.mon.addr  = st.addr_s2;
			next_st.mon.write = ~st.rw_sync[1];
			next_st.mon.hit   = (((st.addr_s2 ^ break_addr) & ~break_mask) == '0) &&
				(break_any_dir || (break_write == ~st.rw_sync[1]));
		end
		// arbitration still answered during manual reset
		next_st.grant_n = st.grant_sync[1] | ext_busy;
		if (mrst && released)
			next_st.grant_n = st.grant_sync[1];
		// refresh counter freezes under manual reset
		next_st.rreq = 1'b0;
		if (!mrst) begin
			if (st.rcnt >= refresh_interval) begin
				next_st.rcnt = REFRESH_RESET;
				next_st.rreq = 1'b1;
			end else begin
				next_st.rcnt = st.rcnt + 16'h0001;
			end
		end
		// current external cycle always runs to its end
		if (st.cur_busy && ext_done)
			next_st.cur_busy = 1'b0;
		// buffered write drains to the external engine
		if (!next_st.cur_busy && st.wbuf_busy && ext_ready && !st.cur_busy) begin
			next_st.cur       = st.wbuf;
			next_st.cur_busy  = 1'b1;
			next_st.wbuf_busy = 1'b0;
		end
		if (wr_accept && st.state == ST_IDLE) begin
			next_st.wbuf      = mk_ext(1'b1, req.size, req.addr, req.wdata);
			next_st.wbuf_busy = 1'b1;
			next_st.wdone     = 1'b1;
			next_st.cwr = cache_enable && area_of(req.addr) == AREA_CACHE && cache_hit;
		end
		unique case (st.state)
			ST_IDLE: begin
				// a read acknowledged this cycle is not taken twice
				if (need_rd && !mrst && !st.rdone) begin
					if (cache_enable && area_of(req.addr) == AREA_CACHE && !req.periph)
						next_st.state = ST_LOOKUP;
					else
						next_st.state = ST_DECIDE;
				end
			end
			ST_LOOKUP: begin
				if (cache_hit) begin
					next_st.rdone = 1'b1;
					next_st.state = ST_IDLE;
				end else begin
					next_st.beat        = 2'h0;
					next_st.fill_cancel = 1'b0;
					next_st.state       = ST_FILL;
				end
			end
			ST_DECIDE: begin
				// dma ext-to-ext read waits for outstanding write
				if (!(src_ext && dst_ext && (st.wbuf_busy || st.cur_busy)))
					next_st.state = ST_READ;
			end
			ST_READ: begin
				if (!st.cur_busy && !st.wbuf_busy && ext_ready) begin
					next_st.cur = mk_ext(1'b0, req.instr ? SIZE_LONG : req.size,
						req.addr, '0);
					next_st.cur_busy = 1'b1;
					next_st.state    = ST_WAITWB;
				end
			end
			ST_WAITWB: begin
				if (st.cur_busy && ext_done) begin
					next_st.rdat  = ext_rdata;
					next_st.rdone = 1'b1;
					next_st.state = ST_IDLE;
				end
			end
			ST_FILL: begin
				if (mrst)
					next_st.fill_cancel = 1'b1;
				if (!st.cur_busy && !st.wbuf_busy && ext_ready && !st.fill_cancel && !mrst) begin
					next_st.cur = mk_ext(1'b0, SIZE_LONG,
						{req.addr[CPU_ADDR_W-1:4], st.beat + req.addr[3:2] + 2'h1, 2'h0},
						'0);
					next_st.cur_busy = 1'b1;
				end
				if (st.cur_busy && ext_done) begin
					next_st.rdat = ext_rdata;
					next_st.cwr  = 1'b1;
					next_st.beat = st.beat + 2'h1;
					if (st.beat == BEAT_LAST) begin
						next_st.rdone = 1'b1;
						next_st.state = ST_IDLE;
					end
				end
				if (st.fill_cancel && !st.cur_busy) begin
					next_st.unsafe = 1'b1;
					next_st.state  = ST_IDLE;
				end
			end
		endcase
		if (st.state == ST_IDLE && need_rd && !mrst && !st.rdone)
			next_st.unsafe = 1'b0;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			// power-on reset only; manual reset leaves settings alone
			st <= '0;
			st.grant_sync  <= 2'h3;
			st.strobe_sync <= 2'h3;
			st.rw_sync     <= 2'h3;
			st.grant_n     <= 1'b1;
			st.state       <= ST_IDLE;
		end else begin
			st <= next_st;
		end
	end

	always_comb begin
		bus_grant_out_n = st.grant_n;
		out_enable_n    = rst | (slave_mode & ~st.cur_busy);
		ctrl_active     = ~rst & st.cur_busy;
		ext_req         = st.cur_busy ? st.cur : '0;
		req_ready       = (req.write & wr_accept & (st.state == ST_IDLE)) | st.rdone;
		rd_done         = st.rdone;
		wr_done         = st.wdone;
		rd_data         = st.rdat;
		cache_write     = st.cwr;
		cache_unsafe    = st.unsafe;
		monitor         = st.mon;
		refresh_req     = st.rreq;
	end
endmodule
`default_nettype wire

// File: shared/bapr_pkg.sv
// Purpose: shared types and constants for the bus access path and reset block
// Assumes: one system clock, synchronous resets
// Notes: widths fixed at the documented values
`default_nettype none
package bapr_pkg;
	localparam int ADDR_W      = 27;
	localparam int CPU_ADDR_W  = 32;
	localparam int DATA_W      = 32;
	localparam int FILL_BEATS  = 4;
	localparam logic [2:0] AREA_CACHE   = 3'h0;
	localparam logic [2:0] AREA_THROUGH = 3'h1;
	localparam logic [1:0] SIZE_LONG    = 2'h2;
	localparam logic [1:0] BEAT_LAST    = 2'h3;
	localparam logic [15:0] REFRESH_RESET = 16'h0000;
	localparam logic [15:0] REFRESH_INTERVAL_DEF = 16'h0200;

	typedef struct packed {
		logic                  valid;
		logic                  write;
		logic                  instr;
		logic                  periph;
		logic                  burst16;
		logic [1:0]            size;
		logic [CPU_ADDR_W-1:0] addr;
		logic [DATA_W-1:0]     wdata;
	} bapr_req_s;

	typedef struct packed {
		logic                  valid;
		logic                  write;
		logic [1:0]            size;
		logic [CPU_ADDR_W-1:0] addr;
		logic [DATA_W-1:0]     wdata;
	} bapr_ext_s;

	typedef struct packed {
		logic              hit;
		logic [ADDR_W-1:0] addr;
		logic              write;
	} bapr_mon_s;

	typedef enum logic [2:0] {
		ST_IDLE, ST_LOOKUP, ST_DECIDE, ST_FILL, ST_READ, ST_WAITWB
	} bapr_state_e;
endpackage
`default_nettype wire

// File: sim/bapr_core_sva.sv
// Purpose: port-level checks of the access path
// Assumes: one clock domain
// Notes: bound to bapr_core
`default_nettype none
module bapr_core_sva
	import bapr_pkg::*;
(
	input wire logic      core_clk,
	input wire logic      rst,
	input wire logic      manual_rst,
	input wire logic      cache_enable,
	input wire logic      bus_cycle_strobe_n,
	input wire logic      bus_release_request_n,
	input wire logic      bus_grant_out_n,
	input wire logic      out_enable_n,
	input wire logic      ctrl_active,
	input wire bapr_req_s req,
	input wire logic      cache_hit,
	input wire logic      req_ready,
	input wire logic      rd_done,
	input wire logic      wr_done,
	input wire bapr_ext_s ext_req,
	input wire bapr_mon_s monitor,
	input wire logic      refresh_req
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_quiet;
		!manual_rst [*3];
	endsequence
	sequence s_hit_take;
		$rose(req.valid) && !req.write && !req.periph && req.addr[31:29] == AREA_CACHE
			&& cache_enable && cache_hit ##1 cache_hit;
	endsequence
	sequence s_released;
		(!bus_release_request_n && !ctrl_active) [*4];
	endsequence
	AST_RST_OUT: assert property (disable iff (1'b0) rst |-> out_enable_n && !ctrl_active
		##1 bus_grant_out_n && !ext_req.valid) else $error("reset outputs");
	AST_WR_DONE: assert property (req_ready && req.valid && req.write |=> wr_done)
		else $error("write completion late");
	AST_HIT_RD: assert property (s_quiet ##0 s_hit_take |-> ##1 rd_done)
		else $error("hit read late");
	AST_REFRESH: assert property (manual_rst [*5] |-> !refresh_req)
		else $error("refresh during manual reset");
	AST_RD_STALL: assert property ((manual_rst && !req.valid) [*3] ##1 manual_rst [*8]
		|-> !rd_done) else $error("read taken in manual reset");
	AST_WB_STALL: assert property (wr_done && ext_req.valid
		|=> !(req_ready && req.write)) else $error("second write taken");
	AST_FILL_LONG: assert property (ext_req.valid && !ext_req.write && cache_enable
		&& !req.periph && ext_req.addr[31:29] == AREA_CACHE |-> ext_req.size == SIZE_LONG)
		else $error("fill not longword");
	AST_FETCH_LONG: assert property (ext_req.valid && !ext_req.write && req.valid
		&& req.instr |-> ext_req.size == SIZE_LONG) else $error("fetch not longword");
	AST_GRANT: assert property (s_released |-> !bus_grant_out_n)
		else $error("grant missing");
	AST_MON: assert property (monitor.hit |-> $past(!bus_cycle_strobe_n, 2)
		|| $past(!bus_cycle_strobe_n, 3)) else $error("monitor hit without strobe");
endmodule
bind bapr_core bapr_core_sva u_sva (.core_clk, .rst, .manual_rst, .cache_enable,
	.bus_cycle_strobe_n, .bus_release_request_n, .bus_grant_out_n, .out_enable_n,
	.ctrl_active, .req, .cache_hit, .req_ready, .rd_done, .wr_done, .ext_req,
	.monitor, .refresh_req);
`default_nettype wire

// File: sim/bapr_ext_model.sv
// Purpose: external cycle engine model answering ext_req
// Assumes: one cycle in flight at a time
// Notes: slow adds wait states; data off-cycle is junk
`default_nettype none
module bapr_ext_model
	import bapr_pkg::*;
(
	// clock and reset
	input  wire logic          core_clk,
	input  wire logic          rst,
	// control
	input  wire logic          slow,
	// engine side
	input  wire bapr_ext_s     ext_req,
	output logic               ext_ready,
	output logic               ext_done,
	output logic [DATA_W-1:0]  ext_rdata
);
	logic              busy;
	int                cnt;
	logic [31:0]       adr;
	logic [31:0]       junk;
	assign ext_ready = !busy;
	always_ff @(posedge core_clk) begin
		junk <= junk * 3 + 32'h0000_0001;
		ext_done <= 1'b0;
		ext_rdata <= ~junk;
		if (rst) begin
			busy <= 1'b0;
			junk <= 32'h0000_0001;
		end else if (!busy && !ext_done && ext_req.valid) begin
			busy <= 1'b1;
			adr <= ext_req.addr;
			cnt <= slow ? 5 : 1;
		end else if (busy && cnt == 0) begin
			busy <= 1'b0;
			ext_done <= 1'b1;
			ext_rdata <= {adr[31:2], 2'b00} ^ 32'hc3a5_5a3c;
		end else if (busy) begin
			cnt <= cnt - 1;
		end
	end
endmodule
`default_nettype wire

// File: sim/tb_bus_access_path_and_reset.sv
// Purpose: self-checking bench for bapr_core
// Assumes: stimulus on falling edge
// Notes: expected read data kept in a queue
`default_nettype none
module tb_bus_access_path_and_reset;
	import bapr_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, rst = 1, manual_rst = 0, cache_hit = 0, bus_owned = 0;
	logic slow = 0, strobe_n = 1, rel_n = 1, gnt_n, oe_n, act, rdy, rdd, wrd, rfr;
	logic xrdy, xdone, cwr, uns, slave_mode = 0, rw_n = 1, src_ext = 0, dst_ext = 0;
	logic [ADDR_W-1:0] baddr, ext_a;
	// bank and precharge bit positions of the column cycle; board-specific
	localparam logic [ADDR_W-1:0] COL_MASK = 27'h000_0c00;
	logic [31:0]       rdat, xdat;
	bapr_req_s         req = '0;
	bapr_ext_s         xr;
	bapr_mon_s         mon;
	int                fails = 0, tests_run = 0, n, i;
	logic [31:0]       q[$];
	always #12.5 core_clk = ~core_clk;
	bapr_core uut (.core_clk, .rst, .manual_rst, .slave_mode, .cache_enable(1'b1),
		.refresh_interval(16'h0020), .break_addr(baddr), .break_mask(COL_MASK),
		.break_write(1'b0), .break_any_dir(1'b1), .bus_cycle_strobe_n(strobe_n),
		.ext_addr_in(ext_a), .ext_rd_wr_n(rw_n), .bus_release_request_n(rel_n),
		.bus_grant_out_n(gnt_n), .out_enable_n(oe_n), .ctrl_active(act), .req,
		.cache_hit, .bus_owned, .src_ext, .dst_ext, .req_ready(rdy),
		.rd_done(rdd), .wr_done(wrd), .rd_data(rdat), .cache_write(cwr), .cache_unsafe(uns),
		.ext_req(xr), .ext_ready(xrdy), .ext_done(xdone), .ext_rdata(xdat),
		.monitor(mon), .refresh_req(rfr));
	bapr_ext_model u_ext (.core_clk, .rst, .slow, .ext_req(xr), .ext_ready(xrdy),
		.ext_done(xdone), .ext_rdata(xdat));
	task chk(string nm, logic [31:0] e, logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	task finish_test;
		$display("fails %0d tests_run %0d", fails, tests_run);
		if (fails == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task access(logic w, logic [31:0] a);
		logic        ok, dn;
		logic [31:0] d;
		int          k;
		@(negedge core_clk);
		req <= '{1'b1, w, 1'($urandom), 1'b0, 1'b0, 2'($urandom % 3), a, $urandom};
		if (!w && !cache_hit) q.push_back({a[31:2], 2'b00} ^ 32'hc3a5_5a3c);
		ok = 0;
		dn = 0;
		d  = '0;
		for (k = 0; k < 80 && !ok; k++) begin
			#1 ok = rdy;
			dn = rdd;
			d  = rdat;
			@(negedge core_clk);
		end
		req.valid <= 1'b0;
		chk("accept", 1, 32'(ok));
		if (w) begin
			chk("wr_done", 1, 32'(wrd));
			chk("cache_write", 32'(a[31:29] == AREA_CACHE && cache_hit), 32'(cwr));
		end else begin
			chk("rd_done", 1, 32'(dn));
			if (!cache_hit) chk("rd_data", q.pop_front(), d);
		end
	endtask
	initial begin
		#200000;
		fails++;
		finish_test;
	end
	initial begin
		void'($urandom(32'h2e78f347));
		baddr = 27'($urandom);
		ext_a = ~baddr;
		repeat (5) @(negedge core_clk);
		chk("grant_n", 1, 32'(gnt_n));
		chk("oe_n", 1, 32'(oe_n));
		rst <= 0;
		fork
			access(1, 32'h2000_0010);
			begin
				n = 0;
				repeat (6) begin
					@(negedge core_clk);
					n += rdy;
				end
				bus_owned <= 1;
			end
		join
		chk("unowned_stall", 0, n);
		for (i = 0; i < 6; i++) begin
			slow <= i[1];
			{src_ext, dst_ext} <= 2'($urandom);
			access(1, {AREA_THROUGH, 27'($urandom), 2'b00});
			access(1, {AREA_THROUGH, 27'($urandom), 2'b00});
			access(0, {i[0] ? AREA_THROUGH : AREA_CACHE, 27'($urandom), 2'b00});
		end
		cache_hit <= 1;
		access(0, 32'h0000_0040);
		access(1, 32'h0000_0080);
		cache_hit <= 0;
		fork
			access(0, 32'h0000_0200);
			begin
				repeat (4) @(negedge core_clk);
				manual_rst <= 1;
				repeat (20) @(negedge core_clk);
				chk("unsafe", 1, 32'(uns));
				manual_rst <= 0;
			end
		join
		while (rfr !== 1'b1) @(negedge core_clk);
		repeat (10) @(negedge core_clk);
		manual_rst <= 1;
		repeat (6) @(negedge core_clk);
		fork
			access(0, 32'h2000_0100);
			begin
				n = 0;
				repeat (20) begin
					@(negedge core_clk);
					n += rdy + rfr;
				end
				manual_rst <= 0;
			end
		join
		chk("manual_stall", 0, n);
		rel_n <= 0;
		repeat (8) @(negedge core_clk);
		chk("grant_low", 0, 32'(gnt_n));
		strobe_n <= 0;
		rw_n <= 0;
		ext_a <= baddr ^ COL_MASK;
		@(negedge core_clk);
		strobe_n <= 1;
		rw_n <= 1;
		ext_a <= ~baddr;
		for (i = 0; i < 8 && mon.hit !== 1'b1; i++) @(negedge core_clk);
		chk("mon_hit", 1, 32'(mon.hit));
		chk("mon_addr", 32'(baddr ^ COL_MASK), 32'(mon.addr));
		chk("mon_write", 1, 32'(mon.write));
		slave_mode <= 1;
		@(negedge core_clk);
		chk("oe_slave", 1, 32'(oe_n));
		finish_test;
	end
endmodule
`default_nettype wire
